// file: adc_port_pkg.sv
// constants shared by the serial result port
package adc_port_pkg;
  localparam int          CLK_MHZ       = 125;
  localparam int          CONV_SLOW_US  = 4000;
  localparam int          CONV_FAST_US  = 1000;
  localparam int          CONV_SLOW_CYC = CONV_SLOW_US * CLK_MHZ;
  localparam int          CONV_FAST_CYC = CONV_FAST_US * CLK_MHZ;
  localparam int          RESULT_BITS   = 16;
  localparam int          CTRL_BITS     = 4;
  localparam int          BIT_KEY_HIGH  = 0;
  localparam int          BIT_KEY_LOW   = 1;
  localparam int          BIT_RATE      = 2;
  localparam int          BIT_REF_PD    = 3;
  localparam logic        RATE_RESET    = 1'b0;
  localparam logic        REF_PD_RESET  = 1'b0;
endpackage : adc_port_pkg

// file: conv_timer.sv
// conversion interval timer
`timescale 1ns/10ps
`default_nettype none
module conv_timer #(
  parameter int SLOW_CYC = 500000,
  parameter int FAST_CYC = 125000
) (
  input  wire logic clk,    // core clock
  input  wire logic rstn,   // async reset, low
  input  wire logic start,  // restart a conversion
  input  wire logic fast,   // short conversion time
  output logic      done    // conversion complete
);
  logic [31:0] count;
  logic        running;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count   <= 32'h0;
      running <= 1'b0;
      done    <= 1'b0;
    end else if (start) begin
      count   <= fast ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1); // [R01] [R02]
      running <= 1'b1;
      done    <= 1'b0;
    end else if (running) begin
      if (count == 32'h0) begin
        running <= 1'b0;
        done    <= 1'b1;
      end else begin
        count <= count - 32'h1;
      end
    end
  end
endmodule : conv_timer
`default_nettype wire

// file: adc_serial_result_port.sv
// serial control and result readout port of the converter
//
// Overview of operation
// [R01] rate 0: conversion takes 4 ms, within 3.2 to 4.8 ms.
// [R02] rate 1: conversion takes 1 ms, within 0.8 to 1.2 ms.
// [R03] output driver enabled while chip select is low.
// [R04] output high impedance while chip select is high.
// [R05] clock and data input ignored while chip select is high.
// [R06] data input carries rate and reference power-down settings, stored.
// [R07] next result bit presented after each falling clock edge.
// [R08] input bit captured on each rising clock edge; only the first four of a data phase are captured.
// [R09] result driven only in the data phase.
// [R10] four-bit word; settings taken only when key bits are 1 then 0.
// [R11] rate 0 gives 208sps, 1 gives 833sps; power-down after next conversion.
// [R12] sign bit first, then remaining bits most significant first.
// [R13] phase ends on sixteenth falling edge or chip select rise; new conversion.
// [R14] conversion timed by internal counter; data phase waits for it.
// [R15] reset clears settings and starts a fresh conversion.
`timescale 1ns/10ps
`default_nettype none
module adc_serial_result_port
  import adc_port_pkg::*;
#(
  parameter int SLOW_CYC = adc_port_pkg::CONV_SLOW_CYC,
  parameter int FAST_CYC = adc_port_pkg::CONV_FAST_CYC
) (
  input  wire logic        clk,          // 125 MHz core clock
  input  wire logic        rstn,         // power-on reset, low
  input  wire logic        cs_n,         // chip select pin, low active
  input  wire logic        sck,          // serial clock pin
  input  wire logic        sdi,          // serial data in pin
  input  wire logic [15:0] sample,       // conversion result from front end
  output logic             sdo,          // serial data out
  output logic             sdo_oe_n,     // output enable, low drives
  output logic             rate_select,  // 1 = fast rate
  output logic             reference_power_down, // ref sleep setting
  output logic             ref_off,      // reference currently off
  output logic             converting    // conversion in progress
);
  import adc_port_pkg::*;

  if (SLOW_CYC < 2 || FAST_CYC < 2) begin : g_bad_counts
    $error("conversion counts too small");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_CONV = 2'b00,
    ST_NAP  = 2'b01,
    ST_DATA = 2'b10
  } phase_e;

  typedef struct packed {
    logic [1:0]  cs_s;
    logic [1:0]  sck_s;
    logic [1:0]  sdi_s;
    logic        sck_d;
    logic        cs_d;
    phase_e      phase;
    logic [15:0] shreg;
    logic [4:0]  nfall;
    logic [2:0]  nrise;
    logic [3:0]  cword;
    logic        rate;
    logic        refpd;
    logic        refoff;
    logic        start;
    logic        sdo;
    logic        oe_n;
    logic        conv;
  } state_s;

  state_s st, next_st;
  logic   conv_done;

  // ----------------------------------------------------------------
  // conversion timer
  // ----------------------------------------------------------------
  conv_timer #(
    .SLOW_CYC (SLOW_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_timer (
    .clk   (clk),
    .rstn  (rstn),
    .start (st.start),
    .fast  (st.rate),
    .done  (conv_done)
  );

  // ----------------------------------------------------------------
  // edge detection on synchronised pins
  // ----------------------------------------------------------------
  logic cs_lo, sck_rise, sck_fall, cs_rise;
  assign cs_lo    = ~st.cs_s[1];
  assign sck_rise = st.sck_s[1] & ~st.sck_d;
  assign sck_fall = ~st.sck_s[1] & st.sck_d;
  assign cs_rise  = st.cs_s[1] & ~st.cs_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.cs_s  = {st.cs_s[0], cs_n};
    next_st.sck_s = {st.sck_s[0], sck};
    next_st.sdi_s = {st.sdi_s[0], sdi};
    next_st.sck_d = st.sck_s[1];
    next_st.cs_d  = st.cs_s[1];
    next_st.start = 1'b0;
    next_st.oe_n  = ~cs_lo;                                   // [R03] [R04]
    unique case (st.phase)
      ST_CONV: begin
        // done of the last conversion stays up until the timer sees start
        if (conv_done && !st.start) begin                     // [R14]
          next_st.phase  = ST_NAP;
          next_st.refoff = st.refpd;                          // [R11]
        end
      end
      ST_NAP: begin
        if (cs_lo) begin
          next_st.phase  = ST_DATA;
          next_st.refoff = 1'b0;
          next_st.shreg  = sample;
          next_st.sdo    = sample[RESULT_BITS-1];             // [R12]
          next_st.nfall  = 5'h0;
          next_st.nrise  = 3'h0;
        end
      end
      ST_DATA: begin
        if (cs_rise || !cs_lo) begin                          // [R05] [R13]
          next_st.phase = ST_CONV;
          next_st.start = 1'b1;
        end else begin
          if (sck_rise && st.nrise < 3'(CTRL_BITS)) begin     // [R08]
            next_st.cword = {st.cword[2:0], st.sdi_s[1]};
            next_st.nrise = st.nrise + 3'h1;
            if (st.nrise == 3'(CTRL_BITS - 1) &&
                st.cword[2] == 1'b1 && st.cword[1] == 1'b0) begin // [R06] [R10]
              next_st.rate  = st.cword[0];
              next_st.refpd = st.sdi_s[1];
            end
          end
          if (sck_fall) begin                                 // [R07] [R12]
            next_st.shreg = {st.shreg[14:0], 1'b0};
            next_st.sdo   = st.shreg[14];
            next_st.nfall = st.nfall + 5'h1;
            if (st.nfall == 5'(RESULT_BITS - 1)) begin        // [R13]
              next_st.phase = ST_CONV;
              next_st.start = 1'b1;
            end
          end
        end
      end
      default: next_st.phase = ST_CONV;
    endcase
    if (st.phase != ST_DATA) next_st.sdo = (st.phase == ST_NAP) ? next_st.sdo : 1'b0; // [R09]
    next_st.conv = (next_st.phase == ST_CONV);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin                                          // [R15]
      st       <= '0;
      st.cs_s  <= 2'b11;
      st.cs_d  <= 1'b1;
      st.oe_n  <= 1'b1;
      st.rate  <= RATE_RESET;
      st.refpd <= REF_PD_RESET;
      st.start <= 1'b1;
      st.phase <= ST_CONV;
      st.conv  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign sdo                  = st.sdo;
  assign sdo_oe_n             = st.oe_n;
  assign rate_select          = st.rate;
  assign reference_power_down = st.refpd;
  assign ref_off              = st.refoff;
  assign converting           = st.conv;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_oe_follows_cs: assert property (@(posedge clk) disable iff (!rstn) // [R04]
    st.cs_s[1] |=> st.oe_n) else $error("sdo driven with cs high");
  a_oe_on_low: assert property (@(posedge clk) disable iff (!rstn) // [R03]
    !st.cs_s[1] |=> !st.oe_n) else $error("sdo not driven with cs low");
  a_msb_first: assert property (@(posedge clk) disable iff (!rstn) // [R12]
    (st.phase == ST_NAP && cs_lo) |=> st.sdo == $past(sample[15]))
    else $error("sign bit not first");
  a_cs_abort: assert property (@(posedge clk) disable iff (!rstn) // [R13]
    (st.phase == ST_DATA && cs_rise) |=> st.phase == ST_CONV && st.start)
    else $error("abort missed");
  a_wait_timer: assert property (@(posedge clk) disable iff (!rstn) // [R14]
    (st.phase == ST_CONV && !conv_done) |=> st.phase == ST_CONV)
    else $error("left conversion early");
  a_fresh_conv: assert property (@(posedge clk) disable iff (!rstn) // [R14]
    st.start |=> st.phase == ST_CONV)
    else $error("stale timer result ended conversion");
  a_ignore_cs_hi: assert property (@(posedge clk) disable iff (!rstn) // [R05]
    (st.phase != ST_DATA) |=> $stable(st.rate) && $stable(st.refpd))
    else $error("setting changed outside data phase");
  a_key_guard: assert property (@(posedge clk) disable iff (!rstn) // [R10]
    (st.phase == ST_DATA && cs_lo && sck_rise && st.nrise == 3'h3 && !(st.cword[2] && !st.cword[1]))
    |=> $stable(st.rate) && $stable(st.refpd)) else $error("settings taken without key");
  a_shift_fall: assert property (@(posedge clk) disable iff (!rstn) // [R07]
    (st.phase == ST_DATA && cs_lo && !cs_rise && sck_fall)
    |=> st.sdo == $past(st.shreg[14])) else $error("bad shift");
  a_quiet_conv: assert property (@(posedge clk) disable iff (!rstn) // [R09]
    (st.phase == ST_CONV) |=> (st.phase != ST_CONV || !st.sdo))
    else $error("data during conversion");
  c_read_done: cover property (@(posedge clk) st.phase == ST_DATA && st.nfall == 5'd15 && sck_fall);
  c_abort:     cover property (@(posedge clk) st.phase == ST_DATA && cs_rise);
  c_program:   cover property (@(posedge clk) st.phase == ST_DATA && st.nrise == 3'd4);
  c_fast_conv: cover property (@(posedge clk) st.phase == ST_CONV && st.rate && conv_done);
  c_ref_sleep: cover property (@(posedge clk) st.phase == ST_NAP && st.refoff);
endmodule : adc_serial_result_port
`default_nettype wire

// file: host_spi_model.sv
// host side model: drives chip select, serial clock and serial data in
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
  input  wire logic        clk,    // core clock
  input  wire logic        sdo_w,  // resolved data out wire
  output logic             cs_n,   // chip select, low active
  output logic             sck,    // serial clock, toggled by noise outside frames
  output logic             sdi,    // serial data in
  output logic [15:0]      rx,     // word read back
  output logic             rx_ok   // one-cycle pulse, word complete
);
  initial begin
    cs_n  = 1'b1;
    sck   = 1'b0;
    sdi   = 1'b0;
    rx    = 16'h0000;
    rx_ok = 1'b0;
  end
  // --------------------------------------------------------------
  // frame: control word out, result in; fewer than 16 bits aborts
  // --------------------------------------------------------------
  task automatic xfer(input logic [3:0] ctrl, input int nbits);
    cs_n <= 1'b0;
    sdi  <= ctrl[3];
    repeat (8) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      sck <= 1'b1;
      rx  <= {rx[14:0], sdo_w}; // bit stands since last fall, first bit since cs_n fell
      repeat (8) @(posedge clk);
      sck <= 1'b0;
      sdi <= (i < 3) ? ctrl[2-i] : ~sdi; // control word bits first, rest ignored
      repeat (8) @(posedge clk);
    end
    cs_n  <= 1'b1; // early rise aborts the read
    rx_ok <= (nbits == 16);
    @(posedge clk);
    rx_ok <= 1'b0;
    sdi   <= ~sdi;
  endtask : xfer
  // pin activity while deselected, a valid-looking word
  task automatic noise();
    for (int i = 0; i < 16; i++) begin
      sck <= ~sck;
      sdi <= (i[2:1] != 2'd1);
      repeat (8) @(posedge clk);
    end
  endtask : noise
endmodule : host_spi_model
`default_nettype wire

// file: adc_serial_result_port_tb.sv
// self-checking bench of the serial result port
`timescale 1ns/10ps
`default_nettype none
module adc_serial_result_port_tb;
  import adc_port_pkg::*;
  localparam int SLOW = 200;
  localparam int FAST = 50;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] sample = 16'h0000;
  logic [15:0] lfsr = 16'h8605;
  logic        cs_n, sck, sdi, sdo, sdo_oe_n, rate_select, reference_power_down;
  logic        ref_off, converting, rx_ok;
  logic [15:0] rx;
  logic [15:0] exp_q[$];
  int          errors = 0;
  int          checks = 0;
  int          run = 0;
  int          last = 0;
  wire logic   sdo_w = sdo_oe_n ? ~sdo : sdo;
  always #4 clk = ~clk;
  adc_serial_result_port #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) u_dut (.clk(clk), .rstn(rstn),
    .cs_n(cs_n), .sck(sck), .sdi(sdi), .sample(sample), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .rate_select(rate_select), .reference_power_down(reference_power_down),
    .ref_off(ref_off), .converting(converting));
  host_spi_model u_host (.clk(clk), .sdo_w(sdo_w), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .rx(rx), .rx_ok(rx_ok));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic wait_idle(input int lo, input int hi, input string name);
    for (int n = 0; n < 2000 && converting !== 1'b0; n++) @(posedge clk);
    check(16'(converting), 16'h0000);
    @(posedge clk);
    check(16'(last >= lo && last <= hi), 16'h0001);
    $display("test %0s done", name);
  endtask : wait_idle
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic read(input logic [3:0] ctrl, input int nbits);
    sample <= lfsr;
    if (nbits == 16) exp_q.push_back(lfsr);
    lfsr = lfsr_next(lfsr);
    u_host.xfer(ctrl, nbits);
  endtask : read
  // ----------------------------------------------------------------
  // monitors
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (converting === 1'b1) run <= run + 1;
    else if (run != 0) begin
      last <= run;
      run  <= 0;
    end
    if (rx_ok === 1'b1) check(rx, exp_q.pop_front());
  end
  always @(negedge cs_n) begin
    repeat (6) @(posedge clk);
    check(16'(sdo_oe_n), 16'h0000);
  end
  always @(posedge cs_n) begin
    repeat (6) @(posedge clk);
    check(16'(sdo_oe_n), 16'h0001);
  end
  initial begin
    #200000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check(16'(rate_select), 16'(RATE_RESET));
    check(16'(reference_power_down), 16'(REF_PD_RESET));
    wait_idle(SLOW * 4 / 5, SLOW * 6 / 5, "reset");
    read(4'b1010, 16);
    check(16'(rate_select), 16'h0001);
    wait_idle(FAST * 4 / 5, FAST * 6 / 5, "fast");
    read(4'b1101, 16);
    check({rate_select, reference_power_down}, 16'h0002);
    wait_idle(FAST * 4 / 5, FAST * 6 / 5, "bad key");
    u_host.noise();
    check({rate_select, reference_power_down}, 16'h0002);
    read(4'b1001, 16);
    check({rate_select, reference_power_down}, 16'h0001);
    wait_idle(SLOW * 4 / 5, SLOW * 6 / 5, "sleep");
    check(16'(ref_off), 16'h0001);
    read(4'b0000, 5);
    repeat (6) @(posedge clk);
    check(16'(converting), 16'h0001);
    wait_idle(SLOW * 4 / 5, SLOW * 6 / 5, "abort");
    read(4'b1000, 16);
    check({rate_select, reference_power_down}, 16'h0000);
    wait_idle(SLOW * 4 / 5, SLOW * 6 / 5, "after abort");
    finish_test();
  end
endmodule : adc_serial_result_port_tb
`default_nettype wire
